// *** src/sdram_command_and_cke_decoder.sv ***
// Command and clock-enable decoder of a DDR3 memory with an AXI4-Lite status port.
`timescale 1ns/1ps
`default_nettype none
module sdram_command_and_cke_decoder (
  // Clock and device reset
  input wire logic mclk,
  input wire logic resetn,
  // Command pins
  input wire ddr3_cmd_pkg::pins_t pins,
  // Decoded commands
  output ddr3_cmd_pkg::cmd_t cmd_out,
  output logic cmd_valid,
  output logic illegal_cmd,
  output ddr3_cmd_pkg::dev_state_t dev_state,
  output logic idle,
  // AXI4-Lite write
  input wire logic [ddr3_cmd_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ddr3_cmd_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import ddr3_cmd_pkg::*;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [NUM_BANKS-1:0] bank_onehot(input logic [BANK_W-1:0] ba);
    bank_onehot = '0;
    bank_onehot[ba] = 1'b1;
  endfunction : bank_onehot

  function automatic logic is_desnop(input pins_t pv);
    is_desnop = pv.cs_n || ({pv.ras_n, pv.cas_n, pv.we_n} == RCW_NOP);
  endfunction : is_desnop

  function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
    is_mapped = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_LAST) ||
                ((a & MODE_BLOCK_MASK) == REG_MODE0 && a[1:0] == 2'h0);
  endfunction : is_mapped

  // ==========================================================================
  // Decoder state
  // ==========================================================================
  logic cke_prev;
  logic cke_wake;
  logic [1:0] pd_kind;
  logic [NUM_BANKS-1:0] open_mask;
  logic [NUM_BANKS-1:0] open_set;
  logic [NUM_BANKS-1:0] close_set;
  logic [2:0] burst_cnt;
  logic burst_auto;
  logic [BANK_W-1:0] burst_bank;
  logic [CNT_W-1:0] pre_cnt;
  logic [CNT_W-1:0] ref_cnt;
  logic [CNT_W-1:0] exit_cnt;
  logic [ADDR_W-1:0] mode_reg [NUM_MODE_REGS];
  logic init_done;
  logic first_long_done;
  logic illegal_sticky;
  logic sr_armed;
  cmd_code_t raw_code;
  logic cmd_ok;

  // The wake path is filtered because the command clock may be stopped in self refresh.
  cke_wake_sync u_wake (
    .mclk(mclk),
    .resetn(resetn),
    .d(pins.cke),
    .q(cke_wake)
  );

  bank_tracker u_banks (
    .mclk(mclk),
    .resetn(resetn),
    .open_set(open_set),
    .close_set(close_set),
    .open_mask(open_mask)
  );

  // ==========================================================================
  // Decode
  // ==========================================================================
  wire [2:0] rcw = {pins.ras_n, pins.cas_n, pins.we_n};
  wire any_open = |open_mask;
  wire burst_busy = burst_cnt != '0;
  // Idle is judged on the state held before the edge, so self refresh entry can pass.
  wire quiet = dev_state == st_active && !any_open && !burst_busy && pre_cnt == '0 &&
               ref_cnt == '0 && exit_cnt == '0;
  wire now_idle = quiet && pins.cke;
  wire bank_open = open_mask[pins.ba];
  wire [1:0] bl_mode = mode_reg[0][MR0_BL_LSB +: 2];
  wire chop = (bl_mode == BL_OTF) ? !pins.addr[A12_BIT] : (bl_mode == BL_FIXED4);
  wire addr_a10 = pins.addr[A10_BIT];

  // Prior state plus clock enable at the previous and present edge pick the action.
  always_comb
  begin
    raw_code = c_illegal;
    case (dev_state)
      st_active:
      begin
        if (cke_prev && pins.cke)
        begin
          if (pins.cs_n)
          begin
            raw_code = c_none;
          end
          else
          begin
            case (rcw)
              RCW_MRW: raw_code = c_mrw;
              RCW_REF: raw_code = c_ref;
              RCW_PRE: raw_code = c_pre;
              RCW_ACT: raw_code = c_act;
              RCW_WR: raw_code = c_wr;
              RCW_RD: raw_code = c_rd;
              RCW_ZQ: raw_code = c_zq;
              default: raw_code = c_nop;
            endcase
          end
        end
        else if (cke_prev && !pins.cke)
        begin
          if (is_desnop(pins))
          begin
            raw_code = c_pde;
          end
          else if (rcw == RCW_REF)
          begin
            raw_code = c_sre;
          end
        end
      end
      st_powerdown:
      begin
        if (!cke_prev && !pins.cke)
        begin
          raw_code = c_none;
        end
        else if (!cke_prev && is_desnop(pins))
        begin
          raw_code = c_pdx;
        end
      end
      st_selfrefresh:
      begin
        raw_code = (cke_wake && sr_armed) ? c_srx : c_none;
      end
      default: raw_code = c_illegal;
    endcase
  end

  // Commands that the present bank and timing state cannot accept are refused.
  always_comb
  begin
    case (raw_code)
      c_act: cmd_ok = !bank_open && exit_cnt == '0;
      c_rd, c_wr: cmd_ok = bank_open && !burst_busy;
      c_mrw, c_ref, c_zq, c_sre: cmd_ok = quiet && cke_prev;
      default: cmd_ok = 1'b1;
    endcase
  end

  wire cmd_code_t fin_code = cmd_ok ? raw_code : c_illegal;
  wire do_act = fin_code == c_act;
  wire do_pre = fin_code == c_pre;
  wire do_burst = fin_code == c_rd || fin_code == c_wr;
  wire burst_end = burst_cnt == BURST_LAST;
  wire [NUM_BANKS-1:0] pre_mask = addr_a10 ? '1 : bank_onehot(pins.ba);
  wire [NUM_BANKS-1:0] auto_mask = (burst_end && burst_auto) ? bank_onehot(burst_bank) : '0;
  assign open_set = do_act ? bank_onehot(pins.ba) : '0;
  assign close_set = (do_pre ? pre_mask : '0) | auto_mask;
  wire start_pre = |(close_set & open_mask);
  wire zq_init_now = addr_a10 && !init_done && !first_long_done;
  wire [1:0] next_pd_kind = (burst_busy || pre_cnt != '0) ? PD_PLAIN :
                            any_open ? PD_ACTIVE : PD_PRECHARGE;
  wire report = fin_code != c_none && fin_code != c_nop && fin_code != c_illegal;

  // ==========================================================================
  // State and timers
  // ==========================================================================
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      dev_state <= st_active;
      pd_kind <= PD_NONE;
      cke_prev <= 1'b0;
      sr_armed <= 1'b0;
    end
    else
    begin
      cke_prev <= pins.cke;
      // Exit waits until the filtered enable was seen low, as stale stages still read high.
      sr_armed <= (dev_state == st_selfrefresh) && (sr_armed || !cke_wake);
      case (fin_code)
        c_pde:
        begin
          dev_state <= st_powerdown;
          pd_kind <= next_pd_kind;
        end
        c_sre: dev_state <= st_selfrefresh;
        c_pdx, c_srx:
        begin
          dev_state <= st_active;
          pd_kind <= PD_NONE;
        end
        default: dev_state <= dev_state;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      burst_cnt <= '0;
      burst_auto <= 1'b0;
      burst_bank <= '0;
    end
    else if (do_burst)
    begin
      burst_cnt <= chop ? BURST4_CYC : BURST8_CYC;
      burst_auto <= addr_a10;
      burst_bank <= pins.ba;
    end
    else if (burst_busy)
    begin
      burst_cnt <= burst_cnt - BURST_LAST;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      pre_cnt <= '0;
      ref_cnt <= '0;
      exit_cnt <= '0;
    end
    else
    begin
      pre_cnt <= start_pre ? PRE_LOAD : (pre_cnt != '0) ? pre_cnt - 1'b1 : pre_cnt;
      ref_cnt <= (fin_code == c_ref) ? REF_LOAD :
                 (ref_cnt != '0) ? ref_cnt - 1'b1 : ref_cnt;
      exit_cnt <= (fin_code == c_pdx) ? PD_EXIT_LOAD :
                  (fin_code == c_srx) ? SR_EXIT_LOAD :
                  (exit_cnt != '0) ? exit_cnt - 1'b1 : exit_cnt;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < NUM_MODE_REGS; i++)
      begin
        mode_reg[i] <= MODE_RESET;
      end
      first_long_done <= 1'b0;
    end
    else
    begin
      if (fin_code == c_mrw)
      begin
        mode_reg[pins.ba[MR_SEL_W-1:0]] <= pins.addr;
      end
      if (fin_code == c_zq && addr_a10)
      begin
        first_long_done <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Decoded outputs
  // ==========================================================================
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cmd_out <= '0;
      cmd_valid <= 1'b0;
      illegal_cmd <= 1'b0;
      idle <= 1'b0;
    end
    else
    begin
      cmd_out <= '{code: fin_code, bank: pins.ba, addr: pins.addr, auto_close: addr_a10,
                   chop: chop, zq_long: addr_a10, zq_init: zq_init_now};
      cmd_valid <= report;
      illegal_cmd <= fin_code == c_illegal;
      idle <= now_idle;
    end
  end

  // ==========================================================================
  // AXI4-Lite slave
  // ==========================================================================
  logic aw_held;
  logic w_held;
  logic [AXI_AW-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] rd_word;

  wire wr_go = aw_held && w_held && !s_axi_bvalid;
  wire wr_ctrl = wr_go && aw_addr == REG_CTRL && w_strb[0];
  wire clr_illegal = wr_go && aw_addr == REG_STATUS && w_strb[1] && w_data[ST_ILLEGAL];
  wire [AXI_AW-1:0] mode_idx = s_axi_araddr >> 2;

  wire [31:0] status_word = {8'h00, open_mask, 7'h00, illegal_sticky, pd_kind,
                             burst_busy, pins.odt, pins.cke, now_idle, 2'(dev_state)};
  wire [31:0] last_word = {cmd_out.addr, 5'h00, cmd_out.zq_init, cmd_out.zq_long,
                           cmd_out.chop, cmd_out.auto_close, cmd_out.bank, 4'(cmd_out.code)};

  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (s_axi_araddr == REG_CTRL)
    begin
      rd_word[CTRL_INIT_DONE] = init_done;
    end
    else if (s_axi_araddr == REG_STATUS)
    begin
      rd_word = status_word;
    end
    else if (s_axi_araddr == REG_LAST)
    begin
      rd_word = last_word;
    end
    else if (is_mapped(s_axi_araddr))
    begin
      rd_word[ADDR_W-1:0] = mode_reg[mode_idx[MR_SEL_W-1:0]];
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      init_done <= 1'b0;
      illegal_sticky <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        init_done <= w_data[CTRL_INIT_DONE];
      end
      illegal_sticky <= (fin_code == c_illegal) || (illegal_sticky && !clr_illegal);
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : sdram_command_and_cke_decoder
`default_nettype wire

// *** src/ddr3_cmd_pkg.sv ***
// Shared constants, register map and carrier types of the command and clock-enable decoder.
package ddr3_cmd_pkg;
  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int BANK_W = 3;
  localparam int ADDR_W = 16;
  localparam int NUM_BANKS = 8;
  localparam int AXI_AW = 8;
  localparam int CNT_W = 8;

  // ==========================================================================
  // Command encodings and address fields
  // ==========================================================================
  localparam logic [2:0] RCW_MRW = 3'h0;
  localparam logic [2:0] RCW_REF = 3'h1;
  localparam logic [2:0] RCW_PRE = 3'h2;
  localparam logic [2:0] RCW_ACT = 3'h3;
  localparam logic [2:0] RCW_WR = 3'h4;
  localparam logic [2:0] RCW_RD = 3'h5;
  localparam logic [2:0] RCW_ZQ = 3'h6;
  localparam logic [2:0] RCW_NOP = 3'h7;
  localparam int A10_BIT = 10;
  localparam int A12_BIT = 12;
  localparam int MR_SEL_W = 2;
  localparam int NUM_MODE_REGS = 4;
  localparam int MR0_BL_LSB = 0;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [ADDR_W-1:0] MODE_RESET = 16'h0000;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_MHZ = 50;
  localparam int PRE_NS = 15;
  localparam int REF_NS = 160;
  localparam int PD_EXIT_NS = 24;
  localparam int SR_EXIT_NS = 170;

  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  localparam logic [CNT_W-1:0] PRE_LOAD = CNT_W'(ns_to_cyc(PRE_NS));
  localparam logic [CNT_W-1:0] REF_LOAD = CNT_W'(ns_to_cyc(REF_NS));
  localparam logic [CNT_W-1:0] PD_EXIT_LOAD = CNT_W'(ns_to_cyc(PD_EXIT_NS));
  localparam logic [CNT_W-1:0] SR_EXIT_LOAD = CNT_W'(ns_to_cyc(SR_EXIT_NS));
  localparam logic [2:0] BURST8_CYC = 3'h4;
  localparam logic [2:0] BURST4_CYC = 3'h2;
  localparam logic [2:0] BURST_LAST = 3'h1;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic odt;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } pins_t;

  typedef enum logic [3:0] {
    c_none, c_nop, c_mrw, c_ref, c_pre, c_act, c_wr, c_rd, c_zq,
    c_sre, c_pde, c_pdx, c_srx, c_illegal
  } cmd_code_t;

  typedef enum logic [1:0] {st_active, st_powerdown, st_selfrefresh} dev_state_t;

  typedef struct packed {
    cmd_code_t code;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic auto_close;
    logic chop;
    logic zq_long;
    logic zq_init;
  } cmd_t;

  localparam logic [1:0] PD_NONE = 2'h0;
  localparam logic [1:0] PD_ACTIVE = 2'h1;
  localparam logic [1:0] PD_PRECHARGE = 2'h2;
  localparam logic [1:0] PD_PLAIN = 2'h3;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] REG_STATUS = 8'h04;
  localparam logic [AXI_AW-1:0] REG_LAST = 8'h08;
  localparam logic [AXI_AW-1:0] REG_MODE0 = 8'h10;
  localparam logic [AXI_AW-1:0] MODE_BLOCK_MASK = 8'hF0;
  localparam int CTRL_INIT_DONE = 0;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_IDLE = 2;
  localparam int ST_CKE = 3;
  localparam int ST_ODT = 4;
  localparam int ST_BURST = 5;
  localparam int ST_PD_LSB = 6;
  localparam int ST_ILLEGAL = 8;
  localparam int ST_OPEN_LSB = 16;
  localparam int LAST_CODE_LSB = 0;
  localparam int LAST_BANK_LSB = 4;
  localparam int LAST_AUTO = 7;
  localparam int LAST_CHOP = 8;
  localparam int LAST_ZQL = 9;
  localparam int LAST_ZQI = 10;
  localparam int LAST_ADDR_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ddr3_cmd_pkg

// *** src/cke_wake_sync.sv ***
// Three-stage synchroniser for clock enable while the command clock may be stopped.
`timescale 1ns/1ps
`default_nettype none
module cke_wake_sync (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Raw and filtered level
  input wire logic d,
  output logic q
);
  logic s1;
  logic s2;
  logic s3;

  // The output moves only when the second and third stages agree.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
      begin
        q <= s3;
      end
    end
  end
endmodule : cke_wake_sync
`default_nettype wire

// *** src/bank_tracker.sv ***
// Open-row flags of all banks.
`timescale 1ns/1ps
`default_nettype none
module bank_tracker (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Open and close requests, one bit per bank
  input wire logic [ddr3_cmd_pkg::NUM_BANKS-1:0] open_set,
  input wire logic [ddr3_cmd_pkg::NUM_BANKS-1:0] close_set,
  // Current flags
  output logic [ddr3_cmd_pkg::NUM_BANKS-1:0] open_mask
);
  import ddr3_cmd_pkg::*;

  genvar i;
  generate
    for (i = 0; i < NUM_BANKS; i++)
    begin : g_bank
      always_ff @(posedge mclk or negedge resetn)
      begin
        if (!resetn)
        begin
          open_mask[i] <= 1'b0;
        end
        else if (open_set[i])
        begin
          open_mask[i] <= 1'b1;
        end
        else if (close_set[i])
        begin
          open_mask[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule : bank_tracker
`default_nettype wire

// *** sim/cmd_decoder_asserts.sv ***
// Checker of command decode and clock-enable state.
`timescale 1ns/1ps
`default_nettype none
module cmd_decoder_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Pins and decode
  input wire ddr3_cmd_pkg::pins_t pins,
  input wire ddr3_cmd_pkg::cmd_t cmd_out,
  input wire logic cmd_valid,
  input wire logic illegal_cmd,
  input wire ddr3_cmd_pkg::dev_state_t dev_state,
  input wire logic idle
);
  import ddr3_cmd_pkg::*;
  localparam cmd_code_t XT [8] = '{c_mrw, c_ref, c_pre, c_act, c_wr, c_rd, c_zq, c_nop};
  logic cke_q;
  wire logic [2:0] rcw = {pins.ras_n, pins.cas_n, pins.we_n};
  wire logic hh = cke_q && pins.cke && dev_state == st_active;
  wire logic rw = cmd_valid && (cmd_out.code == c_rd || cmd_out.code == c_wr);
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      cke_q <= 1'b0;
    else
      cke_q <= pins.cke;
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  // ==========================================================================
  // Assertions
  AST_DES: assert property (hh && pins.cs_n |=> !cmd_valid && !illegal_cmd)
    else $error("deselect started an action");
  AST_NOP: assert property (hh && !pins.cs_n && rcw == 3'h7 |=> !cmd_valid && !illegal_cmd)
    else $error("no-operation started an action");
  AST_DECODE: assert property (hh && !pins.cs_n |=>
    cmd_out.code == XT[$past(rcw)] || cmd_out.code == c_illegal)
    else $error("wrong command decode");
  AST_BANK: assert property (rw |-> cmd_out.bank == $past(pins.ba))
    else $error("wrong bank");
  AST_AUTO: assert property (rw |-> cmd_out.auto_close == $past(pins.addr[A10_BIT]))
    else $error("wrong auto close");
  AST_ZQ: assert property (cmd_valid && cmd_out.code == c_zq |->
    cmd_out.zq_long == $past(pins.addr[A10_BIT]))
    else $error("wrong calibration length");
  AST_ILL: assert property (illegal_cmd |-> cmd_out.code == c_illegal && !cmd_valid)
    else $error("illegal flag mismatch");
  AST_PDE: assert property (cke_q && !pins.cke && dev_state == st_active &&
    (pins.cs_n || rcw == 3'h7) |=> dev_state == st_powerdown)
    else $error("no power-down entry");
  AST_PDK: assert property (dev_state == st_powerdown && !cke_q && !pins.cke |=>
    dev_state == st_powerdown)
    else $error("power-down left with clock enable low");
  AST_IDLE: assert property (idle |-> dev_state == st_active && $past(pins.cke))
    else $error("idle outside active state");
  COV_RD: cover property (rw && cmd_out.chop);
  COV_PD: cover property (dev_state == st_powerdown);
  COV_SRX: cover property (dev_state == st_selfrefresh ##1 dev_state == st_active);
endmodule : cmd_decoder_checker
bind sdram_command_and_cke_decoder cmd_decoder_checker u_chk (.mclk(mclk), .resetn(resetn),
  .pins(pins), .cmd_out(cmd_out), .cmd_valid(cmd_valid), .illegal_cmd(illegal_cmd),
  .dev_state(dev_state), .idle(idle));
`default_nettype wire

// *** sim/ctl_model.sv ***
// Memory controller model that drives the command pins.
`timescale 1ns/1ps
`default_nettype none
module ctl_model (
  // Clock
  input wire logic mclk,
  // Command pins
  output var ddr3_cmd_pkg::pins_t pins
);
  import ddr3_cmd_pkg::*;
  // Deselected with clock enable high, every line at a defined level.
  initial pins = {4'hF, 1'b1, 1'b0, 19'h0};
  task automatic send(input logic cs, input logic [2:0] c, input logic k, input logic [2:0] b,
                      input logic [15:0] a, input logic o);
    pins <= {cs, c, k, o, b, a};
    @(posedge mclk);
    #1;
  endtask : send
endmodule : ctl_model
`default_nettype wire

// *** sim/test_sdram_command_and_cke_decoder.sv ***
// Self-checking bench of the command and clock-enable decoder.
`timescale 1ns/1ps
`default_nettype none
module test_sdram_command_and_cke_decoder;
  import ddr3_cmd_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic odt = 1'b0;
  wire pins_t pins;
  cmd_t cmd_out;
  dev_state_t dev_state;
  logic cmd_valid, illegal_cmd, idle, awr, wr, arr, bv, rv;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic awv = 1'b0, wv = 1'b0, arv = 1'b0, bre = 1'b1, rre = 1'b1;
  logic [3:0] ws = 4'hF;
  logic [31:0] wd = 32'h0, rd, d;
  logic [1:0] br, rr, r;
  int n_fail = 0;
  int checked = 0;
  always #10 mclk = ~mclk;
  sdram_command_and_cke_decoder u_dut (.mclk(mclk), .resetn(resetn), .pins(pins),
    .cmd_out(cmd_out), .cmd_valid(cmd_valid), .illegal_cmd(illegal_cmd),
    .dev_state(dev_state), .idle(idle), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre));
  ctl_model u_ctl (.mclk(mclk), .pins(pins));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic sc(input logic cs, input logic [2:0] c, input logic k, input logic [2:0] b,
                    input logic [15:0] a, input cmd_code_t e);
    logic act;
    u_ctl.send(cs, c, k, b, a, odt);
    act = !(e inside {c_none, c_nop, c_illegal});
    chk({cmd_valid, illegal_cmd}, {act, e == c_illegal});
    chk(cmd_out.code, e);
  endtask : sc
  task automatic no_operation(input int n);
    repeat (n) sc(0, RCW_NOP, 1, 3'h0, 16'h0, c_nop);
  endtask : no_operation
  task automatic burst(input logic [2:0] c, input logic [15:0] a, input logic ch, input logic au);
    sc(0, c, 1, 3'h2, a, c == RCW_RD ? c_rd : c_wr);
    chk({cmd_out.chop, cmd_out.auto_close, cmd_out.bank}, {ch, au, 3'h2});
    no_operation(4);
  endtask : burst
  task automatic axr(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (arr)
        arv <= 1'b0;
    end
    while (!rv);
    d = rd;
    r = rr;
  endtask : axr
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (awr)
        awv <= 1'b0;
      if (wr)
        wv <= 1'b0;
    end
    while (!bv);
    r = br;
  endtask : axw
  task automatic final_report;
    if (n_fail == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  initial
  begin
    #20us;
    n_fail++;
    final_report();
  end
  initial
  begin
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    axr(REG_MODE0);
    chk({r, d}, {RESP_OKAY, 32'h0});
    axr(8'h40);
    chk(r, RESP_SLVERR);
    sc(0, RCW_ACT, 1, 3'h3, 16'h0123, c_act);
    chk({cmd_out.bank, cmd_out.addr}, {3'h3, 16'h0123});
    sc(0, RCW_WR, 1, 3'h3, 16'h0008, c_wr);
    chk(cmd_out.chop, 1'b0);
    sc(0, RCW_RD, 1, 3'h3, 16'h0008, c_illegal);
    no_operation(4);
    sc(0, RCW_PRE, 1, 3'h3, 16'h0, c_pre);
    no_operation(2);
    chk(idle, 1'b1);
    sc(0, RCW_MRW, 1, 3'h0, 16'h0001, c_mrw);
    sc(0, RCW_MRW, 1, 3'h1, 16'h00A5, c_mrw);
    axr(REG_MODE0);
    chk(d, 32'h1);
    axr(8'h14);
    chk(d, 32'hA5);
    sc(0, RCW_ACT, 1, 3'h2, 16'h0040, c_act);
    burst(RCW_RD, 16'h0000, 1, 0);
    chk(idle, 1'b0);
    burst(RCW_RD, 16'h1000, 0, 0);
    burst(RCW_WR, 16'h1000, 0, 0);
    burst(RCW_WR, 16'h0400, 1, 1);
    sc(0, RCW_RD, 1, 3'h2, 16'h1000, c_illegal);
    sc(0, RCW_ZQ, 1, 3'h0, 16'h0400, c_zq);
    chk({cmd_out.zq_long, cmd_out.zq_init}, 2'b11);
    axw(REG_CTRL, 32'h1);
    chk(r, RESP_OKAY);
    sc(0, RCW_ZQ, 1, 3'h0, 16'h0400, c_zq);
    chk({cmd_out.zq_long, cmd_out.zq_init}, 2'b10);
    sc(0, RCW_ZQ, 1, 3'h0, 16'h0000, c_zq);
    chk(cmd_out.zq_long, 1'b0);
    odt = 1'b1;
    sc(1, RCW_ACT, 1, 3'h1, 16'h0, c_none);
    sc(0, RCW_ACT, 1, 3'h1, 16'h0, c_act);
    sc(0, RCW_MRW, 1, 3'h0, 16'h0, c_illegal);
    sc(0, RCW_NOP, 0, 3'h0, 16'h0, c_pde);
    chk(dev_state, st_powerdown);
    axr(REG_STATUS);
    chk(d[7:6], PD_ACTIVE);
    sc(0, RCW_REF, 0, 3'h0, 16'h0, c_none);
    sc(1, RCW_NOP, 1, 3'h0, 16'h0, c_pdx);
    chk(dev_state, st_active);
    no_operation(3);
    sc(0, RCW_PRE, 1, 3'h1, 16'h0, c_pre);
    no_operation(2);
    sc(0, RCW_REF, 0, 3'h0, 16'h0, c_sre);
    chk(dev_state, st_selfrefresh);
    sc(1, RCW_NOP, 0, 3'h0, 16'h0, c_none);
    for (int i = 0; i < 8 && dev_state != st_active; i++)
      u_ctl.send(1, RCW_NOP, 1, 3'h0, 16'h0, odt);
    chk(dev_state, st_active);
    no_operation(10);
    sc(0, RCW_ACT, 1, 3'h4, 16'h0, c_act);
    final_report();
  end
endmodule : test_sdram_command_and_cke_decoder
`default_nettype wire
